// [hdl/rre_exec.sv]
/*
  rre_exec: executes return-from-interrupt, return-with-constant,
  return-from-subroutine and rotate-left-through-carry.
  Assumes the sequencer gives a phase count and a valid instruction word held
  from decode through write; the stack hardware pops on STACK_POP.
*/
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RULE1] Return from interrupt is 0000 0000 0001 000s with s selecting shadow restore.
// [RULE2] Return from interrupt pops the stack and loads the top value into the program counter.
// [RULE3] Return from interrupt sets the high or low global interrupt enable and no other flag.
// [RULE4] With s set, both s-returns copy accumulator, flags and bank pointer shadows to live registers.
// [RULE5] With s clear, accumulator, flags and bank pointer stay untouched on either return.
// [RULE6] Return with constant loads its 8-bit low-byte constant from a 1100 opcode into the accumulator.
// [RULE7] Return with constant also pops the stack into the program counter and affects no flags.
// [RULE8] No return touches the upper and high fetch latches.
// [RULE9] Return from subroutine, prefix 0000 0000 0001, pops into the program counter, plus the shadow restore of [RULE4] when s is set.
// [RULE10] Rotate shifts the byte left, bit 7 to carry, old carry to bit 0, and updates C, N, Z.
// [RULE11] Rotate writes the accumulator when d is zero and the register when d is one.
// [RULE12] Rotate uses the access bank when a is zero, else the bank pointer.
// [RULE13] Returns take two cycles: pop in the write phase of the first, then an idle cycle.
// [RULE14] Subroutine and interrupt returns differ by low nibble 001s versus 000s.
module rre_exec (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic [1:0]  PHASE,
  input  wire logic        INSTR_VALID,
  input  wire logic [15:0] INSTR,
  input  wire logic [20:0] STACK_TOP,
  input  wire logic [7:0]  RF_RDATA,
  input  wire logic        IRQ_PRIORITY_EN,
  input  wire logic        IRQ_IS_HIGH,
  input  wire logic [7:0]  ACCUMULATOR_SHADOW,
  input  wire logic [7:0]  FLAGS_SHADOW,
  input  wire logic [3:0]  BANK_POINTER_SHADOW,
  output logic             STACK_POP,
  output logic             FLUSH,
  output logic [20:0]      PC,
  output logic [7:0]       ACCUMULATOR,
  output logic [7:0]       FLAGS,
  output logic [3:0]       BANK_POINTER,
  output logic             GLOBAL_IRQ_HI_ENABLE,
  output logic             GLOBAL_IRQ_LO_ENABLE,
  output logic [7:0]       RF_RADDR,
  output logic             RF_RBANKED,
  output logic             RF_WE,
  output logic [11:0]      RF_WADDR,
  output logic [7:0]       RF_WDATA
);
  import rre_pkg::*;

  // -----------------------------------------------------------
  // decode
  // -----------------------------------------------------------
  // the two returns are tested first: their patterns are exact, while
  // the constant return and the rotate only match on a prefix.
  // an unknown word decodes to nothing, so a stray fetch never pops
  // the stack or moves the program counter.
  function automatic rre_op_t decode(input logic [15:0] ins);
    if ((ins & RETI_MASK) == RETI_PATTERN) begin
      decode = OP_RETI;                                       // see [RULE1] see [RULE14]
    end else if ((ins & RETS_MASK) == RETS_PATTERN) begin
      decode = OP_RETS;                                       // see [RULE9] see [RULE14]
    end else if (ins[15:12] == RETK_NIBBLE && ins[11:8] == 4'h0) begin
      decode = OP_RETK;                                       // see [RULE6]
    end else if (ins[15:10] == ROT_PREFIX) begin
      decode = OP_ROT;                                        // see [RULE10]
    end else begin
      decode = OP_NONE;
    end
  endfunction : decode

  rre_op_t     op;
  logic        fast;
  logic        is_ret;
  logic        wr_ph;
  logic        idle_ff;
  logic [7:0]  rot_byte_ff;
  logic [7:0]  rot_res;
  logic        rot_c;

  // decode is recomputed every phase; the sequencer must hold the word
  // steady from decode through write or a half-executed mix results
  assign op     = INSTR_VALID ? decode(INSTR) : OP_NONE;
  assign fast   = INSTR[0];
  assign is_ret = (op == OP_RETI) || (op == OP_RETK) || (op == OP_RETS);
  // the second cycle of a return executes nothing; the fetched word is stale
  assign wr_ph  = CE && (PHASE == PH_WRITE) && !idle_ff;

  assign RF_RADDR   = INSTR[7:0];
  assign RF_RBANKED = INSTR[8];                               // see [RULE12]
  assign STACK_POP  = wr_ph && is_ret;                        // see [RULE2] see [RULE7] see [RULE13]
  assign FLUSH      = idle_ff;

  // -----------------------------------------------------------
  // two-cycle return sequencing
  // -----------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      idle_ff <= 1'b0;
    end else if (CE && PHASE == PH_WRITE) begin
      idle_ff <= !idle_ff && is_ret;                          // see [RULE13]
    end
  end

  // -----------------------------------------------------------
  // program counter; fetch latches are not in this block at all
  // -----------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PC <= PC_RST;
    end else if (wr_ph && is_ret) begin
      PC <= STACK_TOP;                                        // see [RULE2] see [RULE7] see [RULE9] see [RULE8]
    end
  end

  // -----------------------------------------------------------
  // rotate datapath
  // -----------------------------------------------------------
  // the operand is captured in the read phase so that the register file
  // read port is free again for the rest of the cycle; the carry used is
  // the live one at the write phase, which no earlier phase can change
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rot_byte_ff <= ROT_BYTE_RST;
    end else if (CE && PHASE == PH_READ && op == OP_ROT) begin
      rot_byte_ff <= RF_RDATA;
    end
  end

  assign rot_res = {rot_byte_ff[6:0], FLAGS[FLG_C]};          // see [RULE10]
  assign rot_c   = rot_byte_ff[7];

  // -----------------------------------------------------------
  // accumulator
  // -----------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ACCUMULATOR <= ACC_RST;
    end else if (wr_ph) begin
      if (op == OP_RETK) begin
        ACCUMULATOR <= INSTR[7:0];                            // see [RULE6]
      end else if ((op == OP_RETI || op == OP_RETS) && fast) begin
        ACCUMULATOR <= ACCUMULATOR_SHADOW;                    // see [RULE4] see [RULE5]
      end else if (op == OP_ROT && !INSTR[9]) begin
        ACCUMULATOR <= rot_res;                               // see [RULE11]
      end
    end
  end

  // -----------------------------------------------------------
  // flags and bank pointer
  // -----------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      FLAGS <= FLAGS_RST;
    end else if (wr_ph) begin
      if ((op == OP_RETI || op == OP_RETS) && fast) begin
        FLAGS <= FLAGS_SHADOW;                                // see [RULE4] see [RULE5]
      end else if (op == OP_ROT) begin
        FLAGS[FLG_C] <= rot_c;                                // see [RULE10]
        FLAGS[FLG_N] <= rot_res[7];
        FLAGS[FLG_Z] <= (rot_res == 8'h00);
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      BANK_POINTER <= BANK_RST;
    end else if (wr_ph && (op == OP_RETI || op == OP_RETS) && fast) begin
      BANK_POINTER <= BANK_POINTER_SHADOW;                    // see [RULE4] see [RULE5]
    end
  end

  // -----------------------------------------------------------
  // interrupt enables; without priority only the master bit is used
  // -----------------------------------------------------------
  // both bits are set only, never cleared here: clearing belongs to the
  // interrupt entry logic outside this block
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      GLOBAL_IRQ_HI_ENABLE <= 1'b0;
      GLOBAL_IRQ_LO_ENABLE <= 1'b0;
    end else if (wr_ph && op == OP_RETI) begin
      if (!IRQ_PRIORITY_EN || IRQ_IS_HIGH) begin
        GLOBAL_IRQ_HI_ENABLE <= 1'b1;                         // see [RULE3]
      end else begin
        GLOBAL_IRQ_LO_ENABLE <= 1'b1;                         // see [RULE3]
      end
    end
  end

  // -----------------------------------------------------------
  // register file writeback
  // -----------------------------------------------------------
  // the write leaves one cycle after the commit edge; a read of the same
  // register in the very next decode phase must be bypassed outside
  rre_wb_if wb_if ();

  assign wb_if.wr_en  = wr_ph && (op == OP_ROT);
  assign wb_if.to_acc = !INSTR[9];                            // see [RULE11]
  assign wb_if.banked = INSTR[8];
  assign wb_if.addr   = INSTR[7:0];
  assign wb_if.data   = rot_res;

  rre_wb u_wb (
    .clk     (CLK_SYS),
    .arst_n  (ARST_N),
    .ce      (CE),
    .bank    (BANK_POINTER),
    .wb      (wb_if.dst),
    .rf_we   (RF_WE),
    .rf_addr (RF_WADDR),
    .rf_data (RF_WDATA)
  );
endmodule : rre_exec
`default_nettype wire

// [hdl/rre_pkg.sv]
/*
  rre_pkg: opcodes, phase encoding, flag positions and reset values for the
  return-and-rotate execution block.
  Assumes a 16-bit instruction word and four core phases per instruction cycle.
*/
package rre_pkg;

  localparam logic [15:0] RETI_PATTERN  = 16'h0010;  // low bit is fast-restore
  localparam logic [15:0] RETI_MASK     = 16'hFFFE;
  localparam logic [15:0] RETS_PATTERN  = 16'h0012;  // low bit is fast-restore
  localparam logic [15:0] RETS_MASK     = 16'hFFFE;
  localparam logic [3:0]  RETK_NIBBLE   = 4'hC;
  localparam logic [5:0]  ROT_PREFIX    = 6'h0D;     // 0011 01

  localparam logic [1:0]  PH_DECODE     = 2'h0;
  localparam logic [1:0]  PH_READ       = 2'h1;
  localparam logic [1:0]  PH_PROCESS    = 2'h2;
  localparam logic [1:0]  PH_WRITE      = 2'h3;

  localparam int          FLG_C         = 0;
  localparam int          FLG_Z         = 2;
  localparam int          FLG_N         = 4;

  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [3:0]  BANK_RST      = 4'h0;
  localparam logic [20:0] PC_RST        = 21'h000000;
  localparam logic [7:0]  ROT_BYTE_RST  = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RETI,
    OP_RETK,
    OP_RETS,
    OP_ROT
  } rre_op_t;

endpackage : rre_pkg

// [hdl/rre_wb_if.sv]
/*
  rre_wb_if: carries the rotate result from the core of the block to the
  writeback stage module.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface rre_wb_if;
  logic       wr_en;
  logic       to_acc;
  logic       banked;
  logic [7:0] addr;
  logic [7:0] data;
  modport src (output wr_en, output to_acc, output banked, output addr, output data);
  modport dst (input wr_en, input to_acc, input banked, input addr, input data);
endinterface : rre_wb_if
`default_nettype wire

// [hdl/rre_wb.sv]
/*
  rre_wb: registered writeback port for the rotate result into the register
  file, forming the full 12-bit address from bank pointer or access bank.
  Assumes the register file accepts one write per strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module rre_wb (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [3:0]  bank,
  rre_wb_if.dst            wb,
  output logic             rf_we,
  output logic [11:0]      rf_addr,
  output logic [7:0]       rf_data
);
  import rre_pkg::*;

  // -----------------------------------------------------------
  // access bank: low half in bank 0, high half in bank 15
  // -----------------------------------------------------------
  function automatic logic [11:0] full_addr(input logic banked, input logic [3:0] b, input logic [7:0] a);
    if (banked) begin
      full_addr = {b, a};
    end else begin
      full_addr = a[7] ? {4'hF, a} : {4'h0, a};
    end
  endfunction : full_addr

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_we   <= 1'b0;
      rf_addr <= 12'h000;
      rf_data <= 8'h00;
    end else if (ce) begin
      rf_we   <= wb.wr_en & ~wb.to_acc;
      rf_addr <= full_addr(wb.banked, bank, wb.addr);  // see [RULE12]
      rf_data <= wb.data;
    end
  end
endmodule : rre_wb
`default_nettype wire

// [test/rre_exec_sva.sv]
/* rre_exec_sva: port-level checks of rre_exec.
   Assumes one clock domain and CE held high by whoever drives the block. */
`timescale 1ns/1ns
`default_nettype none
module rre_exec_sva
  import rre_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic [1:0]  PHASE,
  input wire logic        INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic [20:0] STACK_TOP,
  input wire logic        IRQ_PRIORITY_EN,
  input wire logic        IRQ_IS_HIGH,
  input wire logic [7:0]  ACCUMULATOR_SHADOW,
  input wire logic [7:0]  FLAGS_SHADOW,
  input wire logic [3:0]  BANK_POINTER_SHADOW,
  input wire logic        STACK_POP,
  input wire logic        FLUSH,
  input wire logic [20:0] PC,
  input wire logic [7:0]  ACCUMULATOR,
  input wire logic [7:0]  FLAGS,
  input wire logic [3:0]  BANK_POINTER,
  input wire logic        GLOBAL_IRQ_HI_ENABLE,
  input wire logic        GLOBAL_IRQ_LO_ENABLE,
  input wire logic        RF_WE,
  input wire logic [11:0] RF_WADDR
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  wire        reti   = INSTR[15:1] == RETI_PATTERN[15:1];
  wire        rets   = INSTR[15:1] == RETS_PATTERN[15:1];
  wire        to_lo  = IRQ_PRIORITY_EN && !IRQ_IS_HIGH;
  wire [1:0]  irq_en = {GLOBAL_IRQ_HI_ENABLE, GLOBAL_IRQ_LO_ENABLE};
  wire [6:0]  rot_hd = INSTR[15:9];
  wire [7:0]  lo_b   = INSTR[7:0];
  wire [19:0] live   = {ACCUMULATOR, FLAGS, BANK_POINTER};
  wire [19:0] shadow = {ACCUMULATOR_SHADOW, FLAGS_SHADOW, BANK_POINTER_SHADOW};
  property p_pop_phase; STACK_POP |-> PHASE == PH_WRITE && INSTR_VALID && !FLUSH; endproperty
  a_pop_phase: assert property (p_pop_phase) else $error("pop outside first write phase");
  property p_pop_pc; STACK_POP |=> PC == $past(STACK_TOP); endproperty
  a_pop_pc: assert property (p_pop_pc) else $error("pc not loaded from stack");
  property p_flush; STACK_POP |=> FLUSH [*4] ##1 !FLUSH; endproperty
  a_flush: assert property (p_flush) else $error("idle cycle length wrong");
  property p_irq; STACK_POP && reti |=> irq_en == ($past(irq_en) | ($past(to_lo) ? 2'h1 : 2'h2)); endproperty
  a_irq: assert property (p_irq) else $error("wrong interrupt enable set");
  property p_rets_irq; STACK_POP && rets |=> $stable(irq_en); endproperty
  a_rets_irq: assert property (p_rets_irq) else $error("enable moved on return");
  property p_fast; STACK_POP && (reti || rets) && INSTR[0] |=> live == $past(shadow); endproperty
  a_fast: assert property (p_fast) else $error("shadow restore missing");
  property p_slow; STACK_POP && (reti || rets) && !INSTR[0] |=> $stable(live); endproperty
  a_slow: assert property (p_slow) else $error("live regs moved");
  property p_retk; STACK_POP && INSTR[15:8] == 8'hC0 |=> ACCUMULATOR == $past(lo_b) && $stable(FLAGS); endproperty
  a_retk: assert property (p_retk) else $error("constant not loaded");
  property p_rot_we;
    RF_WE |-> $past(PHASE) == PH_WRITE && $past(rot_hd) == {ROT_PREFIX, 1'h1} && RF_WADDR[7:0] == $past(lo_b);
  endproperty
  a_rot_we: assert property (p_rot_we) else $error("stray register write");
endmodule : rre_exec_sva
bind rre_exec rre_exec_sva u_sva (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PHASE(PHASE), .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR), .STACK_TOP(STACK_TOP), .IRQ_PRIORITY_EN(IRQ_PRIORITY_EN), .IRQ_IS_HIGH(IRQ_IS_HIGH),
  .ACCUMULATOR_SHADOW(ACCUMULATOR_SHADOW), .FLAGS_SHADOW(FLAGS_SHADOW), .BANK_POINTER_SHADOW(BANK_POINTER_SHADOW),
  .STACK_POP(STACK_POP), .FLUSH(FLUSH), .PC(PC), .ACCUMULATOR(ACCUMULATOR), .FLAGS(FLAGS),
  .BANK_POINTER(BANK_POINTER), .GLOBAL_IRQ_HI_ENABLE(GLOBAL_IRQ_HI_ENABLE),
  .GLOBAL_IRQ_LO_ENABLE(GLOBAL_IRQ_LO_ENABLE), .RF_WE(RF_WE), .RF_WADDR(RF_WADDR));
`default_nettype wire

// [test/testbench.sv]
/* testbench: directed scenarios for rre_exec.
   Assumes the bench plays sequencer, stack, register file and shadow copies. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rre_pkg::*;
  logic        clk, arst_n, ce, valid, prio, is_hi, pop, stack_pop, flush, irq_hi, irq_lo, rf_we;
  logic [1:0]  phase;
  logic [15:0] instr;
  logic [20:0] stack_top, pc;
  logic [7:0]  rd_data, acc_sh, flg_sh, acc, flags, exp_flags, rf_wdata;
  logic [3:0]  bank_sh, bank;
  logic [11:0] rf_waddr;
  logic [7:0]  raddr;
  logic        rbanked;
  int          fail_count = 0;
  int          checks = 0;
  rre_exec u_dut (.CLK_SYS(clk), .ARST_N(arst_n), .CE(ce), .PHASE(phase), .INSTR_VALID(valid), .INSTR(instr),
    .STACK_TOP(stack_top), .RF_RDATA(rd_data), .IRQ_PRIORITY_EN(prio), .IRQ_IS_HIGH(is_hi),
    .ACCUMULATOR_SHADOW(acc_sh), .FLAGS_SHADOW(flg_sh), .BANK_POINTER_SHADOW(bank_sh), .STACK_POP(stack_pop),
    .FLUSH(flush), .PC(pc), .ACCUMULATOR(acc), .FLAGS(flags), .BANK_POINTER(bank), .GLOBAL_IRQ_HI_ENABLE(irq_hi),
    .GLOBAL_IRQ_LO_ENABLE(irq_lo), .RF_RADDR(raddr), .RF_RBANKED(rbanked), .RF_WE(rf_we), .RF_WADDR(rf_waddr),
    .RF_WDATA(rf_wdata));
  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one instruction cycle; the pop strobe is combinational, so it is caught inside phase 3
  task automatic run(input logic [15:0] ins, input logic [7:0] rd);
    instr = ins;
    rd_data = rd;
    for (int ph = 0; ph < 4; ph++) begin
      phase = ph[1:0];
      #1 if (ph == 3) pop = stack_pop;
      @(posedge clk);
      #5;
    end
  endtask : run
  // the idle cycle repeats the return with a changed stack top, so a second commit would show
  task automatic ret(input logic [15:0] ins, input logic [20:0] top);
    stack_top = top;
    run(ins, 8'h00);
    chk(pop, 1'h1, "pop");
    chk(pc, top, "pc");
    chk(flush, 1'h1, "idle flag");
    stack_top = ~top;
    run(ins, 8'h00);
    chk(pop, 1'h0, "idle pop");
    chk(pc, top, "idle pc");
    chk(flush, 1'h0, "idle end");
  endtask : ret
  task automatic test_rets;
    ret(16'h0012, 21'h1ABCD4);
    chk({acc, flags, bank}, 20'h0, "slow return regs");
    chk({irq_hi, irq_lo}, 2'h0, "enables");
    $display("test_rets done");
  endtask : test_rets
  task automatic test_retk;
    ret(16'hC0FF, 21'h00ACE2);
    chk(acc, 8'hFF, "constant");
    ret(16'hC03C, 21'h1F0002);
    chk(acc, 8'h3C, "constant");
    chk(flags, 8'h00, "flags kept");
    $display("test_retk done");
  endtask : test_retk
  task automatic test_fast;
    ret(16'h0013, 21'h0F0F0E);
    chk({acc, flags, bank}, {acc_sh, flg_sh, bank_sh}, "fast restore");
    chk({irq_hi, irq_lo}, 2'h0, "enables");
    $display("test_fast done");
  endtask : test_fast
  task automatic test_rot;
    logic [15:0] ins [3] = '{16'h3734, 16'h3490, 16'h3690};
    logic [7:0]  rd [3]  = '{8'h80, 8'h40, 8'h80};
    logic [11:0] wa [3]  = '{12'h934, 12'h000, 12'hF90};
    logic [7:0]  res;
    exp_flags = flg_sh;
    for (int i = 0; i < 3; i++) begin
      res = {rd[i][6:0], exp_flags[FLG_C]};
      exp_flags[FLG_C] = rd[i][7];
      exp_flags[FLG_N] = res[7];
      exp_flags[FLG_Z] = res == 8'h00;
      run(ins[i], rd[i]);
      chk(flags, exp_flags, "rotate flags");
      chk(rf_we, ins[i][9], "write strobe");
      chk({rbanked, raddr}, ins[i][8:0], "read addr");
      if (ins[i][9]) begin
        chk(rf_waddr, wa[i], "write addr");
        chk(rf_wdata, res, "write data");
      end else begin
        chk(acc, res, "acc result");
      end
    end
    $display("test_rot done");
  endtask : test_rot
  task automatic test_reti;
    prio = 1'h1;
    ret(16'h0010, 21'h123456);
    chk({irq_hi, irq_lo}, 2'h1, "low enable");
    chk({acc, flags}, {8'h81, exp_flags}, "slow regs");
    prio = 1'h0;
    ret(16'h0011, 21'h0000F2);
    chk({irq_hi, irq_lo}, 2'h3, "high enable");
    chk({acc, flags, bank}, {acc_sh, flg_sh, bank_sh}, "fast restore");
    $display("test_reti done");
  endtask : test_reti
  // a non-return word must not pop; with the enable low nothing may move
  task automatic test_hold;
    run(16'h0000, 8'h00);
    chk(pop, 1'h0, "nop pop");
    chk(pc, 21'h0000F2, "nop pc");
    ce = 1'h0;
    run(16'h3734, 8'h80);
    chk(pop, 1'h0, "frozen pop");
    chk({acc, flags, bank}, {acc_sh, flg_sh, bank_sh}, "frozen regs");
    chk(rf_we, 1'h0, "frozen write");
    ce = 1'h1;
    $display("test_hold done");
  endtask : test_hold
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    {arst_n, prio, is_hi, phase, instr, stack_top, rd_data} = '0;
    {ce, valid} = 2'h3;
    {acc_sh, flg_sh, bank_sh} = {8'h5A, 8'h01, 4'h9};
    repeat (12) @(posedge clk);
    #5 arst_n = 1'h1;
    test_rets();
    test_retk();
    test_fast();
    test_rot();
    test_reti();
    test_hold();
    close_out();
  end
endmodule : testbench
`default_nettype wire
